/* inc/aisel_params.svh */
// Register offsets, field positions, reset values and sizes for the converter input select block
`ifndef AISEL_PARAMS_SVH
`define AISEL_PARAMS_SVH

// Byte offsets of the converter 1 and converter 2 register words
`define AISEL_OFF_C1_CHS0   8'h00
`define AISEL_OFF_C1_CSSH   8'h04
`define AISEL_OFF_C1_CSSL   8'h08
`define AISEL_OFF_C1_PCFGH  8'h0C
`define AISEL_OFF_C1_PCFGL  8'h10
`define AISEL_OFF_C2_CHS0   8'h14
`define AISEL_OFF_C2_CSSH   8'h18
`define AISEL_OFF_C2_CSSL   8'h1C
`define AISEL_OFF_C2_PCFGL  8'h20

// Channel 0 select field positions
`define AISEL_POS_SEL_A_LSB 0
`define AISEL_POS_SEL_A_MSB 4
`define AISEL_POS_NEG_A     7
`define AISEL_POS_SEL_B_LSB 8
`define AISEL_POS_SEL_B_MSB 12
`define AISEL_POS_NEG_B     15
`define AISEL_CHS0_MASK     16'h9F9F

// All registers clear at reset
`define AISEL_RST_VALUE     16'h0000

// Number of analog inputs addressable by each converter
`define AISEL_NUM_INPUTS    32
`define AISEL_C2_INPUTS     16

`endif

/* inc/aisel_pkg.sv */
// Types for the converter input select block
package aisel_pkg;
   typedef logic [15:0] aisel_word_t;
   typedef logic [4:0] aisel_sel_t;
   // Negative input choice of channel 0
   typedef enum logic {
      AISEL_NEG_LOWREF = 1'b0,
      AISEL_NEG_AN1 = 1'b1
   } aisel_neg_e;
endpackage : aisel_pkg

/* hdl/aisel_top.sv */
// Converter input select, scan mask and pin analog/digital configuration registers
// Operation
// - 5-bit positive select per sample, 11111=AN31
// - Second converter positive select limited to 0-15
// - Set scan bit includes that input
// - Clear scan bit skips that input
// - First converter high scan half maps inputs 16-31
// - Low scan half maps inputs 0-15
// - Set config bit: digital, reader on, ground
// - Clear config bit: analog, pin sampled
// - Config bits always RW, missing pins ignored
// - Second converter has no high config register
// - Both low config registers affect shared pins
// - High config maps 16-31, low 0-15
`include "aisel_params.svh"

module aisel_top
   import aisel_pkg::*;
#(
   parameter int NUM_PINS = `AISEL_NUM_INPUTS,
   parameter logic [31:0] PRESENT_MASK = 32'hFFFFFFFF
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Converter 1 sequencer view
   output logic [4:0] c1_pos_sel_a_o,
   output logic [4:0] c1_pos_sel_b_o,
   output logic c1_neg_an1_a_o,
   output logic c1_neg_an1_b_o,
   output logic [31:0] c1_scan_include_o,
   output logic [31:0] c1_scan_lowref_o,
   // Converter 2 sequencer view
   output logic [4:0] c2_pos_sel_a_o,
   output logic [4:0] c2_pos_sel_b_o,
   output logic c2_neg_an1_a_o,
   output logic c2_neg_an1_b_o,
   output logic [15:0] c2_scan_include_o,
   output logic [15:0] c2_scan_lowref_o,
   // Shared port pins
   output logic [31:0] pin_digital_o,
   output logic [31:0] mux_to_ground_o
);

   aisel_word_t c1_chs0_reg, c1_cssh_reg, c1_cssl_reg, c1_pcfgh_reg, c1_pcfgl_reg;
   aisel_word_t c2_chs0_reg, c2_cssh_reg, c2_cssl_reg, c2_pcfgl_reg;
   aisel_word_t rd_word;
   logic ack_reg;

   // Decode
   wire logic req = wb_cyc_i && wb_stb_i && !ack_reg;
   wire logic wr = req && wb_we_i;
   wire logic hit_c1_chs0 = wb_adr_i == `AISEL_OFF_C1_CHS0;
   wire logic hit_c1_cssh = wb_adr_i == `AISEL_OFF_C1_CSSH;
   wire logic hit_c1_cssl = wb_adr_i == `AISEL_OFF_C1_CSSL;
   wire logic hit_c1_pcfgh = wb_adr_i == `AISEL_OFF_C1_PCFGH;
   wire logic hit_c1_pcfgl = wb_adr_i == `AISEL_OFF_C1_PCFGL;
   wire logic hit_c2_chs0 = wb_adr_i == `AISEL_OFF_C2_CHS0;
   wire logic hit_c2_cssh = wb_adr_i == `AISEL_OFF_C2_CSSH;
   wire logic hit_c2_cssl = wb_adr_i == `AISEL_OFF_C2_CSSL;
   wire logic hit_c2_pcfgl = wb_adr_i == `AISEL_OFF_C2_PCFGL;

   // Byte-lane merge of the low 16 bits; upper lanes have no storage
   function automatic aisel_word_t merge(input aisel_word_t old, input aisel_word_t mask);
      aisel_word_t n;
      n = old;
      if (wb_sel_i[0]) n[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) n[15:8] = wb_dat_i[15:8];
      return n & mask;
   endfunction : merge

   // Unimplemented select bits 6-5 and 14-13 read as zero
   wire aisel_word_t c1_chs0_next = merge(c1_chs0_reg, `AISEL_CHS0_MASK);
   // Second converter positive fields keep only the 0-15 range
   wire aisel_word_t c2_chs0_next = merge(c2_chs0_reg, 16'h8F8F);
   wire aisel_word_t c1_cssh_next = merge(c1_cssh_reg, 16'hFFFF);
   wire aisel_word_t c1_cssl_next = merge(c1_cssl_reg, 16'hFFFF);
   wire aisel_word_t c1_pcfgh_next = merge(c1_pcfgh_reg, 16'hFFFF);
   wire aisel_word_t c1_pcfgl_next = merge(c1_pcfgl_reg, 16'hFFFF);
   wire aisel_word_t c2_cssh_next = merge(c2_cssh_reg, 16'hFFFF);
   wire aisel_word_t c2_cssl_next = merge(c2_cssl_reg, 16'hFFFF);
   wire aisel_word_t c2_pcfgl_next = merge(c2_pcfgl_reg, 16'hFFFF);

   // The second converter's high config offset is not decoded and reads zero
   assign rd_word = hit_c1_chs0 ? c1_chs0_reg :
                    hit_c1_cssh ? c1_cssh_reg :
                    hit_c1_cssl ? c1_cssl_reg :
                    hit_c1_pcfgh ? c1_pcfgh_reg :
                    hit_c1_pcfgl ? c1_pcfgl_reg :
                    hit_c2_chs0 ? c2_chs0_reg :
                    hit_c2_cssh ? c2_cssh_reg :
                    hit_c2_cssl ? c2_cssl_reg :
                    hit_c2_pcfgl ? c2_pcfgl_reg : 16'h0000;

   // Single-cycle answer; unmapped addresses ack with zero data and no effect
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ack_reg <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         ack_reg <= req;
         wb_dat_o <= req ? {16'h0000, rd_word} : 32'h00000000;
      end
   end
   assign wb_ack_o = ack_reg;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         c1_chs0_reg <= `AISEL_RST_VALUE;
         c1_cssh_reg <= `AISEL_RST_VALUE;
         c1_cssl_reg <= `AISEL_RST_VALUE;
         c1_pcfgh_reg <= `AISEL_RST_VALUE;
         c1_pcfgl_reg <= `AISEL_RST_VALUE;
         c2_chs0_reg <= `AISEL_RST_VALUE;
         c2_cssh_reg <= `AISEL_RST_VALUE;
         c2_cssl_reg <= `AISEL_RST_VALUE;
         c2_pcfgl_reg <= `AISEL_RST_VALUE;
      end else if (wr) begin
         if (hit_c1_chs0) c1_chs0_reg <= c1_chs0_next;
         if (hit_c1_cssh) c1_cssh_reg <= c1_cssh_next;
         if (hit_c1_cssl) c1_cssl_reg <= c1_cssl_next;
         if (hit_c1_pcfgh) c1_pcfgh_reg <= c1_pcfgh_next;
         if (hit_c1_pcfgl) c1_pcfgl_reg <= c1_pcfgl_next;
         if (hit_c2_chs0) c2_chs0_reg <= c2_chs0_next;
         if (hit_c2_cssh) c2_cssh_reg <= c2_cssh_next;
         if (hit_c2_cssl) c2_cssl_reg <= c2_cssl_next;
         if (hit_c2_pcfgl) c2_pcfgl_reg <= c2_pcfgl_next;
      end
   end

   // Sequencer and pin views
   wire logic [31:0] c1_scan_mask = {c1_cssh_reg, c1_cssl_reg};
   wire logic [15:0] c2_scan_mask = c2_cssl_reg;
   // Either converter marking a shared low pin digital wins
   wire logic [31:0] digital_cfg = {c1_pcfgh_reg, c1_pcfgl_reg | c2_pcfgl_reg};
   // Absent pins ignore their config bits and stay non-digital
   wire logic [31:0] digital_eff = digital_cfg & PRESENT_MASK;

   // Registered copies so every output is a flip-flop
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         c1_pos_sel_a_o <= 5'h00;
         c1_pos_sel_b_o <= 5'h00;
         c1_neg_an1_a_o <= 1'b0;
         c1_neg_an1_b_o <= 1'b0;
         c2_pos_sel_a_o <= 5'h00;
         c2_pos_sel_b_o <= 5'h00;
         c2_neg_an1_a_o <= 1'b0;
         c2_neg_an1_b_o <= 1'b0;
         c1_scan_include_o <= 32'h00000000;
         c1_scan_lowref_o <= 32'h00000000;
         c2_scan_include_o <= 16'h0000;
         c2_scan_lowref_o <= 16'h0000;
         pin_digital_o <= 32'h00000000;
         mux_to_ground_o <= 32'h00000000;
      end else begin
         c1_pos_sel_a_o <= c1_chs0_reg[`AISEL_POS_SEL_A_MSB:`AISEL_POS_SEL_A_LSB];
         c1_pos_sel_b_o <= c1_chs0_reg[`AISEL_POS_SEL_B_MSB:`AISEL_POS_SEL_B_LSB];
         c1_neg_an1_a_o <= c1_chs0_reg[`AISEL_POS_NEG_A];
         c1_neg_an1_b_o <= c1_chs0_reg[`AISEL_POS_NEG_B];
         c2_pos_sel_a_o <= c2_chs0_reg[`AISEL_POS_SEL_A_MSB:`AISEL_POS_SEL_A_LSB];
         c2_pos_sel_b_o <= c2_chs0_reg[`AISEL_POS_SEL_B_MSB:`AISEL_POS_SEL_B_LSB];
         c2_neg_an1_a_o <= c2_chs0_reg[`AISEL_POS_NEG_A];
         c2_neg_an1_b_o <= c2_chs0_reg[`AISEL_POS_NEG_B];
         c1_scan_include_o <= c1_scan_mask;
         // Selected but absent inputs convert the low reference
         c1_scan_lowref_o <= c1_scan_mask & ~PRESENT_MASK;
         c2_scan_include_o <= c2_scan_mask;
         c2_scan_lowref_o <= c2_scan_mask & ~PRESENT_MASK[15:0];
         pin_digital_o <= digital_eff;
         mux_to_ground_o <= digital_eff;
      end
   end

   // Checks
   sequence s_write_full(logic [7:0] adr);
      req && wb_we_i && wb_adr_i == adr && (&wb_sel_i[1:0]);
   endsequence
   sequence s_read_at(logic [7:0] adr);
      req && !wb_we_i && wb_adr_i == adr;
   endsequence

   a_sel_a_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr && hit_c1_chs0 && wb_sel_i[0] |-> ##2 c1_pos_sel_a_o == $past(wb_dat_i[4:0], 2))
      else $error("sample A select did not follow write");
   a_neg_b_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr && hit_c1_chs0 && wb_sel_i[1] |-> ##2 c1_neg_an1_b_o == $past(wb_dat_i[15], 2))
      else $error("sample B negative select wrong");
   a_c2_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !c2_pos_sel_a_o[4] && !c2_pos_sel_b_o[4])
      else $error("second converter select above 15");
   a_scan_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr && hit_c1_cssh && (&wb_sel_i[1:0]) |-> ##2 c1_scan_include_o[31:16] == $past(wb_dat_i[15:0], 2))
      else $error("high scan half mismatch");
   a_scan_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr && hit_c1_cssl && (&wb_sel_i[1:0]) |-> ##2 c1_scan_include_o[15:0] == $past(wb_dat_i[15:0], 2))
      else $error("low scan half mismatch");
   a_scan_lowref: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (c1_scan_lowref_o & ~c1_scan_include_o) == 32'h00000000)
      else $error("low reference on unselected input");
   a_shared_or: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 pin_digital_o[15:0] == ($past(c1_pcfgl_reg | c2_pcfgl_reg) & PRESENT_MASK[15:0]))
      else $error("shared pin mode not the union");
   a_ground_mux: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      mux_to_ground_o == pin_digital_o)
      else $error("digital pin not grounded at mux");
   a_ack_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held beyond one cycle");
   a_no_c2_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      req && !wb_we_i && wb_adr_i == 8'h24 |=> wb_dat_o == 32'h00000000)
      else $error("second converter high config readable");

   // Bus answer
   a_ack_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      req |=> wb_ack_o)
      else $error("request not answered");

   a_ack_needs_req: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wb_ack_o |-> $past(req))
      else $error("ack without request");

   a_dat_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data outside ack");

   a_dat_upper: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wb_dat_o[31:16] == 16'h0000)
      else $error("upper read half not zero");

   // Reset leaves every view cleared, so no reset filter here
   a_reset_clear: assert property (@(posedge clk_i)
      sys_rst_i |=> !wb_ack_o && pin_digital_o == 32'h00000000 && c1_scan_include_o == 32'h00000000)
      else $error("outputs not cleared by reset");

   // Channel 0 select fields
   a_sel_b_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_write_full(`AISEL_OFF_C1_CHS0) |-> ##2 c1_pos_sel_b_o == $past(wb_dat_i[12:8], 2))
      else $error("sample B select did not follow write");

   a_neg_a_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_write_full(`AISEL_OFF_C1_CHS0) |-> ##2 c1_neg_an1_a_o == $past(wb_dat_i[7], 2))
      else $error("sample A negative select wrong");

   a_c2_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_write_full(`AISEL_OFF_C2_CHS0) |-> ##2 c2_pos_sel_a_o == {1'b0, $past(wb_dat_i[3:0], 2)})
      else $error("second converter sample A select wrong");

   a_c2_sel_b: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_write_full(`AISEL_OFF_C2_CHS0) |-> ##2 c2_pos_sel_b_o == {1'b0, $past(wb_dat_i[11:8], 2)})
      else $error("second converter sample B select wrong");

   a_c2_neg_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_write_full(`AISEL_OFF_C2_CHS0) |-> ##2 c2_neg_an1_a_o == $past(wb_dat_i[7], 2))
      else $error("second converter sample A negative wrong");

   a_c2_neg_b: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_write_full(`AISEL_OFF_C2_CHS0) |-> ##2 c2_neg_an1_b_o == $past(wb_dat_i[15], 2))
      else $error("second converter sample B negative wrong");

   a_chs0_gaps: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (c1_chs0_reg & ~`AISEL_CHS0_MASK) == 16'h0000)
      else $error("unimplemented select bits set");

   a_c2_gaps: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (c2_chs0_reg & 16'h7070) == 16'h0000)
      else $error("second converter select above range");

   // Scan masks
   a_c2_scan_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_write_full(`AISEL_OFF_C2_CSSL) |-> ##2 c2_scan_include_o == $past(wb_dat_i[15:0], 2))
      else $error("second converter scan mask mismatch");

   a_scan_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 (~c1_scan_include_o & $past({c1_cssh_reg, c1_cssl_reg})) == 32'h00000000)
      else $error("selected input left out of scan");

   a_scan_skip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 (c1_scan_include_o & ~$past({c1_cssh_reg, c1_cssl_reg})) == 32'h00000000)
      else $error("cleared input still scanned");

   a_c2_skip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 (c2_scan_include_o & ~$past(c2_cssl_reg)) == 16'h0000)
      else $error("second converter scans cleared input");

   a_lowref_absent: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (c1_scan_lowref_o & PRESENT_MASK) == 32'h00000000)
      else $error("present input flagged as low reference");

   a_c2_lowref: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (c2_scan_lowref_o & PRESENT_MASK[15:0]) == 16'h0000)
      else $error("second converter flags present input");

   a_lowref_map: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 c1_scan_lowref_o == ($past({c1_cssh_reg, c1_cssl_reg}) & ~PRESENT_MASK))
      else $error("absent scanned input not flagged");

   // Pin configuration
   a_digital_absent: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (pin_digital_o & ~PRESENT_MASK) == 32'h00000000)
      else $error("absent pin marked digital");

   a_pcfgh_map: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_write_full(`AISEL_OFF_C1_PCFGH) |-> ##2 pin_digital_o[31:16] == ($past(wb_dat_i[15:0], 2) & PRESENT_MASK[31:16]))
      else $error("high config half mismatch");

   a_c1_low_joint: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 ($past(c1_pcfgl_reg) & PRESENT_MASK[15:0] & ~pin_digital_o[15:0]) == 16'h0000)
      else $error("first converter low config ignored");

   a_c2_low_joint: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 ($past(c2_pcfgl_reg) & PRESENT_MASK[15:0] & ~pin_digital_o[15:0]) == 16'h0000)
      else $error("second converter low config ignored");

   a_analog_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 (pin_digital_o[15:0] & ~$past(c1_pcfgl_reg | c2_pcfgl_reg)) == 16'h0000)
      else $error("analog pin marked digital");

   a_pcfgl_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_read_at(`AISEL_OFF_C1_PCFGL) |=> wb_dat_o == {16'h0000, $past(c1_pcfgl_reg)})
      else $error("low config readback wrong");

   a_unmapped_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      req && wb_we_i && wb_adr_i == 8'h24 |=> $stable(c1_pcfgh_reg) && $stable(c2_pcfgl_reg) && $stable(c2_cssh_reg))
      else $error("unmapped write changed a register");

   a_read_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      req && !wb_we_i |=> $stable(c1_chs0_reg) && $stable(c1_cssl_reg) && $stable(c1_pcfgl_reg))
      else $error("read changed a register");

endmodule : aisel_top

/* test/aisel_seq_model.sv */
// Sequencer and pin model: counts what one scan sweep would convert
module aisel_seq_model (
   // Block outputs
   input wire logic [31:0] scan_include_i,
   input wire logic [31:0] scan_lowref_i,
   input wire logic [31:0] pin_digital_i,
   // Sweep totals
   output logic [5:0] pin_conv_o,
   output logic [5:0] lowref_conv_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // A digital pin has its mux on ground, so it never counts as a sampled pin
   always_comb begin
      pin_conv_o = 6'h00;
      lowref_conv_o = 6'h00;
      for (int n = 0; n < 32; n++) begin
         if (scan_include_i[n] && scan_lowref_i[n]) begin
            lowref_conv_o += 6'h01;
         end else if (scan_include_i[n] && !pin_digital_i[n]) begin
            pin_conv_o += 6'h01;
         end
      end
   end
endmodule : aisel_seq_model

/* test/tb.sv */
// Register-level testbench for the converter input select block
`include "aisel_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // Inputs 24-31 absent, so scanning them gives the low reference
   localparam logic [31:0] PRESENT = 32'h00FFFFFF;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd, c1_inc, c1_vr, pin_dig, mux_gnd;
   logic wb_ack_o, c1_na, c1_nb, c2_na, c2_nb;
   logic [4:0] c1_sa, c1_sb, c2_sa, c2_sb;
   logic [15:0] c2_inc, c2_vr;
   logic [5:0] pin_conv, lowref_conv;
   int miscompares = 0;
   int checks = 0;
   logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};

   aisel_top #(.NUM_PINS(32), .PRESENT_MASK(PRESENT)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .c1_pos_sel_a_o(c1_sa),
      .c1_pos_sel_b_o(c1_sb), .c1_neg_an1_a_o(c1_na), .c1_neg_an1_b_o(c1_nb), .c1_scan_include_o(c1_inc),
      .c1_scan_lowref_o(c1_vr), .c2_pos_sel_a_o(c2_sa), .c2_pos_sel_b_o(c2_sb), .c2_neg_an1_a_o(c2_na),
      .c2_neg_an1_b_o(c2_nb), .c2_scan_include_o(c2_inc), .c2_scan_lowref_o(c2_vr),
      .pin_digital_o(pin_dig), .mux_to_ground_o(mux_gnd));
   aisel_seq_model u_seq (.scan_include_i(c1_inc), .scan_lowref_i(c1_vr), .pin_digital_i(pin_dig),
      .pin_conv_o(pin_conv), .lowref_conv_o(lowref_conv));

   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One classic cycle; ack is sampled at the edge, then the request is dropped
   task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         miscompares++;
         summarize();
      end else begin
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
      end
   endtask : wb

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      wb(1'b1, adr, 4'h3, dat);
   endtask : wr

   task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 4'hF, 32'h0);
      chk(rd, exp);
   endtask : rchk

   // Sequencer and pin outputs follow the register by one edge
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      foreach (offs[i]) rchk(offs[i], 32'h0);
      chk(pin_dig, 32'h0);
      wr(`AISEL_OFF_C1_CHS0, 32'hFFFF);
      rchk(`AISEL_OFF_C1_CHS0, 32'h9F9F);
      wr(`AISEL_OFF_C1_CHS0, 32'h851E);
      wr(`AISEL_OFF_C2_CHS0, 32'hFFFF);
      rchk(`AISEL_OFF_C2_CHS0, 32'h8F8F);
      settle();
      chk({20'h0, c1_sa, c1_sb, c1_na, c1_nb}, {20'h0, 5'h1E, 5'h05, 1'b0, 1'b1});
      chk({20'h0, c2_sa, c2_sb, c2_na, c2_nb}, {20'h0, 5'h0F, 5'h0F, 1'b1, 1'b1});
      wr(`AISEL_OFF_C1_CSSH, 32'hA5C3);
      wr(`AISEL_OFF_C1_CSSL, 32'h0F01);
      wr(`AISEL_OFF_C2_CSSL, 32'h1234);
      settle();
      chk(c1_inc, 32'hA5C30F01);
      chk(c1_vr, 32'hA5000000);
      chk({16'h0, c2_inc}, 32'h1234);
      chk({26'h0, pin_conv}, 32'h9);
      chk({26'h0, lowref_conv}, 32'h4);
      chk({16'h0, c2_vr}, 32'h0);
      wr(`AISEL_OFF_C1_PCFGH, 32'hFFFF);
      wr(`AISEL_OFF_C1_PCFGL, 32'h00F0);
      wr(`AISEL_OFF_C2_PCFGL, 32'h0F00);
      settle();
      chk(pin_dig, 32'h00FF0FF0);
      chk(mux_gnd, 32'h00FF0FF0);
      chk({26'h0, pin_conv}, 32'h1);
      rchk(`AISEL_OFF_C1_PCFGH, 32'hFFFF);
      wr(`AISEL_OFF_C1_PCFGL, 32'h0);
      settle();
      chk(pin_dig, 32'h00FF0F00);
      wr(8'h24, 32'hFFFF);
      rchk(8'h24, 32'h0);
      wb(1'b1, `AISEL_OFF_C1_CSSL, 4'h2, 32'hFFFF);
      rchk(`AISEL_OFF_C1_CSSL, 32'hFF01);
      summarize();
   end
endmodule : tb
